// [hw/sdt_regs.vh]
`ifndef SDT_REGS_VH
`define SDT_REGS_VH

// Step angle position.
`define SDT_POS_W        6
`define SDT_POS_RESET    6'h00
`define SDT_MAG_ZERO     6'h00
`define SDT_MAG_FULL     6'h3F

// Effective resolution codes.
`define SDT_MODE_FULL    2'h0
`define SDT_MODE_HALF    2'h1
`define SDT_MODE_QUARTER 2'h2
`define SDT_MODE_SIXTEEN 2'h3

// Grid spacing and grid offset of each resolution.
`define SDT_GRID_FULL    6'h10
`define SDT_GRID_HALF    6'h08
`define SDT_GRID_QUARTER 6'h04
`define SDT_GRID_SIXTEEN 6'h01
`define SDT_OFS_FULL     6'h08
`define SDT_OFS_OTHER    6'h00

// Resolution configuration register.
`define SDT_CFG_RES_RESET 2'h0

// Fault status and position register layout.
`define SDT_FLT_W         16
`define SDT_FLT_SUMMARY   15
`define SDT_FLT_THERM_HI  14
`define SDT_FLT_THERM_LO  13
`define SDT_FLT_OV        12
`define SDT_FLT_UV        11
`define SDT_FLT_STALL     10
`define SDT_FLT_OLB       9
`define SDT_FLT_OLA       8
`define SDT_FLT_POS_HI    5
`define SDT_FLT_POS_LO    0
`define SDT_FLT_RESET     16'h0000

// Thermal indicator codes.
`define SDT_THERM_OK      2'h0
`define SDT_THERM_COLD    2'h1
`define SDT_THERM_HOT     2'h2
`define SDT_THERM_SHUT    2'h3

`endif

// [hw/sdt_edge_sync.v]
`timescale 1ns/1ps
`include "sdt_regs.vh"

module sdt_edge_sync (
   input  wire       sys_clk,
   input  wire       srst,
   input  wire [3:0] rawIn,
   output wire [3:0] syncOut,
   output wire       stepRise
);

   // All four controls share one latency, so direction and resolution
   // stay aligned with the step edge they were set up for.
   reg [3:0] stage1_r;
   reg [3:0] stage2_r;
   reg       stepPrev_r;

   always @(posedge sys_clk) begin
      if (srst) begin
         stage1_r   <= 4'h0;
         stage2_r   <= 4'h0;
         stepPrev_r <= 1'b0;
      end else begin
         stage1_r   <= rawIn;
         stage2_r   <= stage1_r;
         stepPrev_r <= stage2_r[0];
      end
   end

   assign syncOut  = stage2_r;
   assign stepRise = stage2_r[0] & ~stepPrev_r;

endmodule // sdt_edge_sync

// [hw/sdt_phase_table.v]
`timescale 1ns/1ps
`include "sdt_regs.vh"

module sdt_phase_table (
   input  wire [5:0] position,
   output reg  [5:0] phaseAMag,
   output reg        phaseANeg,
   output reg  [5:0] phaseBMag,
   output reg        phaseBNeg
);

   // Quarter sinusoid; 100 percent cannot be coded in 6 bits, so it clips to 63.
   function [5:0] quarterSine;
      input [4:0] idx;
      begin
         case (idx)
            5'h00: quarterSine = 6'h00;
            5'h01: quarterSine = 6'h06;
            5'h02: quarterSine = 6'h0C;
            5'h03: quarterSine = 6'h12;
            5'h04: quarterSine = 6'h18;
            5'h05: quarterSine = 6'h1E;
            5'h06: quarterSine = 6'h23;
            5'h07: quarterSine = 6'h28;
            5'h08: quarterSine = 6'h2D;
            5'h09: quarterSine = 6'h31;
            5'h0A: quarterSine = 6'h35;
            5'h0B: quarterSine = 6'h38;
            5'h0C: quarterSine = 6'h3B;
            5'h0D: quarterSine = 6'h3D;
            5'h0E: quarterSine = 6'h3E;
            default: quarterSine = 6'h3F;
         endcase
      end
   endfunction

   wire [4:0] fwdIdx = {1'b0, position[3:0]};
   wire [4:0] revIdx = 5'h10 - {1'b0, position[3:0]};

   // Position 0 is phase B full positive, phase A zero; each step is 5.625 degrees.
   always @* begin
      phaseAMag = quarterSine(position[4] ? revIdx : fwdIdx);
      phaseBMag = quarterSine(position[4] ? fwdIdx : revIdx);
      phaseANeg = position[5] & (phaseAMag != 6'h00);
      phaseBNeg = (position[5] ^ position[4]) & (phaseBMag != 6'h00);
   end

endmodule // sdt_phase_table

// [hw/sdt_translator.v]
// Behaviour
// - Position indexes a 64-entry phase table, entries 0 to 63.
// - Finest resolution is one sixteenth step; 16 microsteps per full step.
// - Table entry gives magnitude and sign for both phases.
// - Each phase setpoint is a 6-bit value.
// - Position 0 is phase B full, phase A zero; 5.625 degrees per step.
// - Resolution 00 full, 01 half, 10 quarter, 11 sixteenth.
// - Effective select bit is pin OR register bit; register bits reset zero.
// - Sixteenth resolution moves position by one per step rising edge.
// - Direction high increases position, low decreases it.
// - Full step uses only positions 8, 24, 40, 56.
// - Half step uses only multiples of 8.
// - Quarter step uses only multiples of 4.
// - After resolution change, next edge goes to nearest allowed position onward.
// - Serial position changes ignore resolution select.
// - Thermal code 00 none, 01 cold, 10 hot, 11 shutdown.
// - Fault status register reports position in its low field plus flags.
// - Separate flags for overvoltage, undervoltage, stall, open load A and B.
// - Position arithmetic wraps modulo 64.
`timescale 1ns/1ps
`include "sdt_regs.vh"

module sdt_translator (
   input  wire        sys_clk,
   input  wire        srst,
   input  wire        stepIn,
   input  wire        dirIn,
   input  wire        resolutionSelLo,
   input  wire        resolutionSelHi,
   input  wire        cfgResWrEn,
   input  wire [1:0]  cfgResWrData,
   input  wire        serialStrobeN,
   input  wire [5:0]  serialStepChange,
   input  wire [1:0]  thermalIndicator,
   input  wire        supplyOverVolt,
   input  wire        regulatorUnderVolt,
   input  wire        stallFlag,
   input  wire        openLoadPhaseA,
   input  wire        openLoadPhaseB,
   output reg  [5:0]  position_r,
   output reg  [5:0]  phaseAMag_r,
   output reg         phaseANeg_r,
   output reg  [5:0]  phaseBMag_r,
   output reg         phaseBNeg_r,
   output reg  [1:0]  effResolution_r,
   output reg  [15:0] faultStatusPosition_r
);

   // Grid spacing of a resolution code.
   function [5:0] gridOf;
      input [1:0] mode;
      begin
         case (mode)
            `SDT_MODE_FULL:    gridOf = `SDT_GRID_FULL;
            `SDT_MODE_HALF:    gridOf = `SDT_GRID_HALF;
            `SDT_MODE_QUARTER: gridOf = `SDT_GRID_QUARTER;
            default:           gridOf = `SDT_GRID_SIXTEEN;
         endcase
      end
   endfunction

   // Grid offset of a resolution code; full step sits on the 45 degree points.
   function [5:0] offsetOf;
      input [1:0] mode;
      begin
         case (mode)
            `SDT_MODE_FULL: offsetOf = `SDT_OFS_FULL;
            default:        offsetOf = `SDT_OFS_OTHER;
         endcase
      end
   endfunction

   // Next allowed position in the commanded direction. A position off the
   // grid snaps to the nearest grid point ahead, so a resolution change takes
   // effect on the first edge without an overshoot.
   function [5:0] nextPosition;
      input [5:0] pos;
      input [1:0] mode;
      input       fwd;
      reg   [5:0] grid;
      reg   [5:0] ofs;
      reg   [5:0] rel;
      reg   [5:0] base;
      begin
         grid = gridOf(mode);
         ofs  = offsetOf(mode);
         rel  = pos - ofs;
         base = rel & ~(grid - 6'h01);
         if (fwd) begin
            nextPosition = base + grid + ofs;
         end else if (rel == base) begin
            nextPosition = base - grid + ofs;
         end else begin
            nextPosition = base + ofs;
         end
      end
   endfunction

   wire [3:0] syncCtl;
   wire       stepRise;
   wire [5:0] tabAMag;
   wire       tabANeg;
   wire [5:0] tabBMag;
   wire       tabBNeg;

   reg  [1:0] cfgRes_r;
   reg        strobePrev_r;
   reg  [1:0] effRes;
   reg  [5:0] posAfterStep;
   reg  [5:0] position_nxt;
   reg        serialStep;
   reg        faultSummary;

   sdt_edge_sync u_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .rawIn    ({resolutionSelHi, resolutionSelLo, dirIn, stepIn}),
      .syncOut  (syncCtl),
      .stepRise (stepRise)
   );

   sdt_phase_table u_table (
      .position  (position_nxt),
      .phaseAMag (tabAMag),
      .phaseANeg (tabANeg),
      .phaseBMag (tabBMag),
      .phaseBNeg (tabBNeg)
   );

   // Resolution configuration bits; cleared so the pins rule when unused.
   always @(posedge sys_clk) begin
      if (srst) begin
         cfgRes_r <= `SDT_CFG_RES_RESET;
      end else if (cfgResWrEn) begin
         cfgRes_r <= cfgResWrData;
      end
   end

   // Serial step fires on the low-to-high transition of the strobe.
   always @(posedge sys_clk) begin
      if (srst) begin
         strobePrev_r <= 1'b1;
      end else begin
         strobePrev_r <= serialStrobeN;
      end
   end

   always @* begin
      serialStep = serialStrobeN & ~strobePrev_r;
      effRes     = {syncCtl[3] | cfgRes_r[1], syncCtl[2] | cfgRes_r[0]};
   end

   // Step edge first, then the serial change, so a coincident pair loses
   // neither move. The serial change is a raw two's complement offset.
   always @* begin
      if (stepRise) begin
         posAfterStep = nextPosition(position_r, effRes, syncCtl[1]);
      end else begin
         posAfterStep = position_r;
      end
      if (serialStep) begin
         position_nxt = posAfterStep + serialStepChange;
      end else begin
         position_nxt = posAfterStep;
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         position_r <= `SDT_POS_RESET;
      end else begin
         position_r <= position_nxt;
      end
   end

   // Setpoints follow the position with no extra delay.
   always @(posedge sys_clk) begin
      if (srst) begin
         phaseAMag_r <= `SDT_MAG_ZERO;
         phaseANeg_r <= 1'b0;
         phaseBMag_r <= `SDT_MAG_FULL;
         phaseBNeg_r <= 1'b0;
      end else begin
         phaseAMag_r <= tabAMag;
         phaseANeg_r <= tabANeg;
         phaseBMag_r <= tabBMag;
         phaseBNeg_r <= tabBNeg;
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         effResolution_r <= `SDT_MODE_FULL;
      end else begin
         effResolution_r <= effRes;
      end
   end

   always @* begin
      faultSummary = (thermalIndicator != `SDT_THERM_OK) | supplyOverVolt |
                     regulatorUnderVolt | stallFlag | openLoadPhaseA | openLoadPhaseB;
   end

   // Status image; the position field reflects the updated position.
   always @(posedge sys_clk) begin
      if (srst) begin
         faultStatusPosition_r <= `SDT_FLT_RESET;
      end else begin
         faultStatusPosition_r <= `SDT_FLT_RESET;
         faultStatusPosition_r[`SDT_FLT_SUMMARY] <= faultSummary;
         faultStatusPosition_r[`SDT_FLT_THERM_HI:`SDT_FLT_THERM_LO] <= thermalIndicator;
         faultStatusPosition_r[`SDT_FLT_OV]    <= supplyOverVolt;
         faultStatusPosition_r[`SDT_FLT_UV]    <= regulatorUnderVolt;
         faultStatusPosition_r[`SDT_FLT_STALL] <= stallFlag;
         faultStatusPosition_r[`SDT_FLT_OLB]   <= openLoadPhaseB;
         faultStatusPosition_r[`SDT_FLT_OLA]   <= openLoadPhaseA;
         faultStatusPosition_r[`SDT_FLT_POS_HI:`SDT_FLT_POS_LO] <= position_nxt;
      end
   end

endmodule // sdt_translator

// [verif/sdt_translator_asserts.sv]
`timescale 1ns/1ps
`include "sdt_regs.vh"

module sdt_translator_asserts (
   input wire        sys_clk,
   input wire        srst,
   input wire        stepIn,
   input wire        dirIn,
   input wire        resolutionSelLo,
   input wire        resolutionSelHi,
   input wire        serialStrobeN,
   input wire [1:0]  thermalIndicator,
   input wire        supplyOverVolt,
   input wire        regulatorUnderVolt,
   input wire        stallFlag,
   input wire        openLoadPhaseA,
   input wire        openLoadPhaseB,
   input wire [5:0]  position_r,
   input wire [5:0]  phaseAMag_r,
   input wire [5:0]  phaseBMag_r,
   input wire        phaseBNeg_r,
   input wire [1:0]  effResolution_r,
   input wire [15:0] faultStatusPosition_r
);
   // A window of recent input edges; it is wide enough to cover the synchroniser delay.
   reg  [7:0] stepHist_r;
   reg  [7:0] strbHist_r;
   wire       serRecent = |(strbHist_r[6:0] & ~strbHist_r[7:1]);
   wire       actRecent = serRecent | (|(stepHist_r[6:0] & ~stepHist_r[7:1]));
   wire [6:0] flagsIn = {thermalIndicator, supplyOverVolt, regulatorUnderVolt, stallFlag,
                         openLoadPhaseB, openLoadPhaseA};
   wire [1:0] pinsIn = {resolutionSelHi, resolutionSelLo};

   always @(posedge sys_clk) begin
      stepHist_r <= srst ? 8'h00 : {stepHist_r[6:0], stepIn};
      strbHist_r <= srst ? 8'hFF : {strbHist_r[6:0], serialStrobeN};
   end

   function gridOk(input [1:0] m, input [5:0] p);
      gridOk = (m == `SDT_MODE_FULL) ? (p[3:0] == 4'h8) :
               (m == `SDT_MODE_HALF) ? (p[2:0] == 3'h0) :
               (m == `SDT_MODE_QUARTER) ? (p[1:0] == 2'h0) : 1'b1;
   endfunction

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_STEP_MOVES:
      assert property ($rose(stepIn) && !serRecent |-> ##[2:4] $changed(position_r))
      else $error("step edge did not move the position");
   AST_HOLD:
      assert property ($changed(position_r) |-> actRecent)
      else $error("position moved without a step or strobe");
   AST_GRID:
      assert property ($changed(position_r) && !serRecent && $stable(effResolution_r)
         |-> gridOk(effResolution_r, position_r))
      else $error("position off the grid of the resolution");
   AST_UNIT:
      assert property ($changed(position_r) && !serRecent && $stable(effResolution_r)
         && effResolution_r == `SDT_MODE_SIXTEEN
         |-> position_r == $past(position_r) + (dirIn ? 6'h01 : 6'h3F))
      else $error("sixteenth step did not move by one");
   AST_FAULT_POS:
      assert property (faultStatusPosition_r[7:0] == {2'h0, position_r})
      else $error("fault register position field wrong");
   AST_FAULT_FLAGS:
      assert property (!$past(srst) |-> faultStatusPosition_r[14:8] == $past(flagsIn))
      else $error("fault flags do not follow inputs");
   AST_SUMMARY:
      assert property (faultStatusPosition_r[15] == |faultStatusPosition_r[14:8])
      else $error("fault summary wrong");
   AST_PINS_OR:
      assert property ((!srst && $stable(pinsIn))[*4] |-> (effResolution_r & pinsIn) == pinsIn)
      else $error("resolution pin not reflected");
   AST_PHASE_ZERO:
      assert property (position_r == 6'h00
         |-> phaseAMag_r == 6'h00 && phaseBMag_r == 6'h3F && !phaseBNeg_r)
      else $error("phase currents wrong at position zero");
endmodule // sdt_translator_asserts

bind sdt_translator sdt_translator_asserts sdt_translator_asserts_i (.sys_clk(sys_clk),
   .srst(srst), .stepIn(stepIn), .dirIn(dirIn), .resolutionSelLo(resolutionSelLo),
   .resolutionSelHi(resolutionSelHi), .serialStrobeN(serialStrobeN),
   .thermalIndicator(thermalIndicator), .supplyOverVolt(supplyOverVolt),
   .regulatorUnderVolt(regulatorUnderVolt), .stallFlag(stallFlag),
   .openLoadPhaseA(openLoadPhaseA), .openLoadPhaseB(openLoadPhaseB),
   .position_r(position_r), .phaseAMag_r(phaseAMag_r), .phaseBMag_r(phaseBMag_r),
   .phaseBNeg_r(phaseBNeg_r), .effResolution_r(effResolution_r),
   .faultStatusPosition_r(faultStatusPosition_r));

// [verif/sdt_host_model.sv]
`timescale 1ns/1ps

module sdt_host_model (
   input  wire sys_clk,
   output reg  stepIn,
   output reg  dirIn,
   output reg  resolutionSelLo,
   output reg  resolutionSelHi
);
   initial begin
      stepIn = 1'b0;
      dirIn = 1'b1;
      {resolutionSelHi, resolutionSelLo} = 2'h0;
   end

   // Direction and resolution settle three cycles ahead of the edge, so the
   // synchronisers never see them change together with the step.
   task step(input fwd, input [1:0] pins, input integer slow);
      begin
         @(posedge sys_clk);
         #1 dirIn = fwd;
         {resolutionSelHi, resolutionSelLo} = pins;
         repeat (3) @(posedge sys_clk);
         #1 stepIn = 1'b1;
         repeat (2 + slow) @(posedge sys_clk);
         #1 stepIn = 1'b0;
         repeat (6 + slow) @(posedge sys_clk);
         #1;
      end
   endtask
endmodule // sdt_host_model

// [verif/sdt_translator_tb.sv]
`timescale 1ns/1ps
`include "sdt_regs.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
   n_errors = n_errors + 1; $display("unexpected at %0t: %h vs %h", $time, g, e); end end

module sdt_translator_tb;
   reg         sys_clk = 1'b0;
   reg         srst = 1'b1;
   wire        stepIn, dirIn, resolutionSelLo, resolutionSelHi;
   reg         cfgResWrEn = 1'b0;
   reg  [1:0]  cfgResWrData = 2'h0;
   reg         serialStrobeN = 1'b1;
   reg  [5:0]  serialStepChange = 6'h00;
   reg  [6:0]  flags = 7'h00;
   wire [5:0]  position_r, phaseAMag_r, phaseBMag_r;
   wire        phaseANeg_r, phaseBNeg_r;
   wire [1:0]  effResolution_r;
   wire [15:0] faultStatusPosition_r;
   reg  [31:0] seed = 32'h0000000C;
   reg  [5:0]  expPos = 6'h00;
   reg  [1:0]  cfgBits = 2'h0;
   integer     n_errors = 0;
   integer     compares = 0;
   integer     i;

   always #50 sys_clk = ~sys_clk;

   sdt_host_model host_i (.sys_clk(sys_clk), .stepIn(stepIn), .dirIn(dirIn),
      .resolutionSelLo(resolutionSelLo), .resolutionSelHi(resolutionSelHi));
   sdt_translator sdt_translator_i (.sys_clk(sys_clk), .srst(srst), .stepIn(stepIn),
      .dirIn(dirIn), .resolutionSelLo(resolutionSelLo), .resolutionSelHi(resolutionSelHi),
      .cfgResWrEn(cfgResWrEn), .cfgResWrData(cfgResWrData), .serialStrobeN(serialStrobeN),
      .serialStepChange(serialStepChange), .thermalIndicator(flags[6:5]),
      .supplyOverVolt(flags[4]), .regulatorUnderVolt(flags[3]), .stallFlag(flags[2]),
      .openLoadPhaseB(flags[1]), .openLoadPhaseA(flags[0]), .position_r(position_r),
      .phaseAMag_r(phaseAMag_r), .phaseANeg_r(phaseANeg_r), .phaseBMag_r(phaseBMag_r),
      .phaseBNeg_r(phaseBNeg_r), .effResolution_r(effResolution_r),
      .faultStatusPosition_r(faultStatusPosition_r));

   function [31:0] xorshift(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xorshift = y ^ (y << 5);
      end
   endfunction

   // Off grid the reverse target is the grid point below, on grid one point back.
   function [5:0] nextPos(input [5:0] p, input [1:0] m, input fwd);
      integer g, o, r;
      begin
         g = (m == 2'h0) ? 16 : (m == 2'h1) ? 8 : (m == 2'h2) ? 4 : 1;
         o = (m == 2'h0) ? 8 : 0;
         r = (p - o + 64) % 64;
         r = fwd ? (r / g + 1) * g : ((r % g) ? r / g * g : r - g);
         nextPos = r + o;
      end
   endfunction

   function [5:0] mag(input [4:0] k);
      reg [101:0] t;
      begin
         t = {6'h3F, 6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h38, 6'h35, 6'h31, 6'h2D,
              6'h28, 6'h23, 6'h1E, 6'h18, 6'h12, 6'h0C, 6'h06, 6'h00};
         mag = t[k * 6 +: 6];
      end
   endfunction

   task checkAll;
      reg [5:0] a, b;
      reg       na, nb;
      begin
         a = mag(expPos[4] ? 5'h10 - expPos[3:0] : {1'b0, expPos[3:0]});
         b = mag(expPos[4] ? {1'b0, expPos[3:0]} : 5'h10 - expPos[3:0]);
         na = expPos[5] && a != 6'h00;
         nb = (expPos[5] ^ expPos[4]) && b != 6'h00;
         `CHK(position_r, expPos)
         `CHK(faultStatusPosition_r, {|flags, flags, 2'h0, expPos})
         `CHK({phaseAMag_r, phaseBMag_r, phaseANeg_r, phaseBNeg_r}, {a, b, na, nb})
      end
   endtask

   task doStep(input fwd, input [1:0] pins, input integer slow);
      begin
         host_i.step(fwd, pins, slow);
         expPos = nextPos(expPos, pins | cfgBits, fwd);
         checkAll;
         `CHK(effResolution_r, pins | cfgBits)
      end
   endtask

   task serial(input [5:0] v);
      begin
         serialStepChange = v;
         serialStrobeN = 1'b0;
         repeat (2) @(posedge sys_clk);
         #1 serialStrobeN = 1'b1;
         repeat (4) @(posedge sys_clk);
         #1 expPos = expPos + v;
         checkAll;
      end
   endtask

   task cfgWrite(input [1:0] v);
      begin
         cfgResWrData = v;
         cfgResWrEn = 1'b1;
         @(posedge sys_clk);
         #1 cfgResWrEn = 1'b0;
         cfgBits = v;
         @(posedge sys_clk);
         #1;
      end
   endtask

   task final_report;
      begin
         $display("compares %0d errors %0d", compares, n_errors);
         if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   initial begin
      #2000000;
      n_errors = n_errors + 1;
      final_report;
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      #1 srst = 1'b0;
      @(posedge sys_clk);
      #1 checkAll;
      doStep(1'b0, 2'h3, 0);
      serial(6'h3C);
      doStep(1'b1, 2'h2, 0);
      serial(6'h3F);
      doStep(1'b1, 2'h1, 1);
      serial(6'h3B);
      doStep(1'b1, 2'h0, 0);
      doStep(1'b0, 2'h0, 0);
      cfgWrite(2'h3);
      doStep(1'b1, 2'h0, 0);
      cfgWrite(2'h0);
      for (i = 0; i < 80; i = i + 1) begin
         seed = xorshift(seed);
         flags = seed[14:8];
         if (seed[7:5] == 3'h0)
            serial(seed[21:16]);
         else if (seed[7:5] == 3'h1)
            cfgWrite(seed[23:22]);
         else
            doStep(seed[4], seed[3:2], seed[1:0]);
      end
      cfgWrite(2'h0);
      doStep(1'b1, 2'h0, 0);
      `CHK(position_r[3:0], 4'h8)
      final_report;
   end
endmodule // sdt_translator_tb
